// file: hw/mbd_pkg.sv
// constants, word views and the decoded bundle for mbd_decoder
// assumes one core clock and 16-bit program memory words
package mbd_pkg;
	localparam int unsigned WORD_W = 16;
	localparam int unsigned FLAG_W = 5;
	typedef logic [WORD_W-1:0] mbd_word_t;
	typedef logic [11:0] mbd_ptr_t;
	typedef logic [19:0] mbd_addr_t;
	// top nibble groups
	localparam logic [3:0] NIB_ZERO = 4'h0;
	localparam logic [3:0] NIB_BIT_TOG = 4'h7;
	localparam logic [3:0] NIB_BIT_SET = 4'h8;
	localparam logic [3:0] NIB_BIT_CLR = 4'h9;
	localparam logic [3:0] NIB_SKIP_SET = 4'hA;
	localparam logic [3:0] NIB_SKIP_CLR = 4'hB;
	localparam logic [3:0] NIB_CTRL = 4'hE;
	localparam logic [3:0] NIB_OPERAND = 4'hF;
	// second nibble codes
	localparam logic [2:0] UP_CALL = 3'h6;
	localparam logic [3:0] MID_JUMP = 4'hF;
	localparam logic [3:0] MID_PTR = 4'hE;
	localparam logic [3:0] MID_ZERO = 4'h0;
	localparam logic [3:0] MID_BANK = 4'h1;
	localparam logic [3:0] MID_SUBL = 4'h8;
	localparam logic [3:0] MID_ORL = 4'h9;
	localparam logic [3:0] MID_XORL = 4'hA;
	localparam logic [3:0] MID_ANDL = 4'hB;
	localparam logic [3:0] MID_LRET = 4'hC;
	localparam logic [3:0] MID_MULL = 4'hD;
	localparam logic [3:0] MID_MOVL = 4'hE;
	localparam logic [3:0] MID_ADDL = 4'hF;
	// low byte codes under 0000 0000
	localparam logic [7:0] LO_SLEEP = 8'h03;
	localparam logic [7:0] LO_PUSH = 8'h05;
	localparam logic [7:0] LO_POP = 8'h06;
	localparam logic [6:0] LO_IRET = 7'h08;
	localparam logic [5:0] LO_TBL_RD = 6'h02;
	localparam logic [5:0] LO_TBL_WR = 6'h03;
	localparam logic [3:0] LO_BANK_HI = 4'h0;
	localparam logic [1:0] PTR_PAD = 2'h0;
	// branch condition groups
	localparam logic [1:0] CG_ZERO = 2'h0;
	localparam logic [1:0] CG_CARRY = 2'h1;
	localparam logic [1:0] CG_OVER = 2'h2;
	localparam logic [1:0] CG_NEG = 2'h3;
	// flag indices and masks
	localparam int unsigned FI_CARRY = 0;
	localparam int unsigned FI_ZERO = 2;
	localparam int unsigned FI_OVER = 3;
	localparam int unsigned FI_NEG = 4;
	localparam logic [4:0] MASK_ARITH = 5'h1F;
	localparam logic [4:0] MASK_LOGIC = 5'h14;
	localparam logic [1:0] CYC_ONE = 2'h1;
	localparam logic [1:0] CYC_TWO = 2'h2;
	localparam logic [1:0] CYC_THREE = 2'h3;
	localparam logic [1:0] SQ_NONE = 2'h0;
	localparam logic [1:0] SQ_ONE = 2'h1;
	localparam logic [1:0] SQ_TWO = 2'h2;
	// register port map
	localparam logic [2:0] A_CTRL = 3'h0;
	localparam logic [2:0] A_TMR = 3'h1;
	localparam logic [2:0] A_PLO = 3'h2;
	localparam logic [2:0] A_PHI = 3'h3;
	localparam logic [2:0] A_ILL = 3'h4;
	localparam logic [2:0] A_STATE = 3'h5;
	localparam int unsigned CTRL_PSA = 0;
	localparam int unsigned CTRL_PINS = 1;
	localparam logic [7:0] RST_CTRL = 8'h02;
	localparam logic [7:0] RST_TMR = 8'h00;
	localparam logic [7:0] RST_PLO = 8'h80;
	localparam logic [7:0] RST_PHI = 8'h84;
	typedef enum logic [4:0] {
		OP_NONE, OP_BIT_CLR, OP_BIT_SET, OP_BIT_TOG,
		OP_SKIP_CLR, OP_SKIP_SET, OP_BRANCH, OP_CALL,
		OP_JUMP, OP_POP, OP_PUSH, OP_IRQ_RET, OP_LIT_RET,
		OP_SLEEP, OP_PTR_LOAD, OP_BANK_LOAD, OP_LIT_ADD,
		OP_LIT_SUB, OP_LIT_AND, OP_LIT_OR, OP_LIT_XOR,
		OP_LIT_MOVE, OP_LIT_MUL, OP_TBL_READ, OP_TBL_WRITE
	} mbd_op_e;
	typedef struct packed {
		logic [3:0] hi;
		logic [3:0] mid;
		logic [7:0] lo;
	} mbd_word_s;
	typedef struct packed {
		logic [3:0] hi;
		logic [2:0] bitIdx;
		logic access;
		logic [7:0] addr;
	} mbd_bitw_s;
	typedef struct packed {
		logic [3:0] hi;
		logic [2:0] up;
		logic fast;
		logic [7:0] lo;
	} mbd_ctl_s;
	typedef struct packed {
		logic [3:0] hi;
		logic far;
		logic [1:0] grp;
		logic inv;
		logic [7:0] lo;
	} mbd_br_s;
	typedef struct packed {
		logic [1:0] pad;
		logic [1:0] sel;
		logic [3:0] lit;
	} mbd_ptrb_s;
	typedef struct packed {
		logic [5:0] head;
		logic [1:0] mode;
	} mbd_tail_s;
	typedef struct packed {
		logic [6:0] head;
		logic fast;
	} mbd_ret_s;
	typedef struct packed {
		mbd_op_e op;
		logic valid;
		logic squashed;
		logic illegal;
		logic [1:0] cycles;
		logic [4:0] flagMask;
		logic [2:0] bitIdx;
		logic access;
		logic [7:0] fileAddr;
		logic [7:0] literal;
		mbd_addr_t target;
		logic [1:0] ptrSel;
		mbd_ptr_t ptrValue;
		logic fast;
		logic [1:0] tblMode;
		logic skipTaken;
		logic branchTaken;
		logic irqReEnable;
		logic standby;
		logic tpStatusUpd;
		logic pinSource;
		logic prescalerClear;
	} mbd_dec_s;
endpackage : mbd_pkg

// file: hw/mbd_decoder.sv
// decoder for bit, control, literal and table program words
// assumes fetch, flags and tested bit come from core-clock logic
//
// Contract
// - top nibble selects bit clear/set/toggle/test
// - bit test skip: 1, else 2 or 3
// - conditional branch: 1, taken 2 cycles
// - call spans two words, 2 cycles, fast
// - jump spans two words, 2 cycles
// - lone 1111 word is one-cycle nop
// - stack discard word, one cycle
// - stack push word, one cycle
// - interrupt return re-enables, fast restore, 2
// - literal return loads literal, 2 cycles
// - standby word updates timeout/powerdown status
// - pointer load two words, 12-bit literal
// - bank literal into low four bits
// - literal add/subtract set all five flags
// - literal and/or/xor set zero, negative
// - literal move/multiply touch no flags
// - table read with four pointer modes
// - table write with four pointer modes
// - port read-modify-write sources the pins
// - timer zero modify clears prescaler
`timescale 1ns/1ps
`default_nettype none
module mbd_decoder (
	input wire logic ref_clk,
	input wire logic rst_b,
	input wire logic fetchValid,
	input wire mbd_pkg::mbd_word_t fetchWord,
	input wire mbd_pkg::mbd_word_t nextWord,
	input wire logic [mbd_pkg::FLAG_W-1:0] flagsIn,
	input wire logic bitValue,
	input wire logic [2:0] regAddr,
	input wire logic [7:0] regWdata,
	input wire logic regWr,
	input wire logic regRd,
	output logic [7:0] regRdata,
	output var mbd_pkg::mbd_dec_s decOut
);

////////////////////////////////////////////////////////////////
// word views

mbd_pkg::mbd_word_s w;
mbd_pkg::mbd_bitw_s bw;
mbd_pkg::mbd_ctl_s cw;
mbd_pkg::mbd_br_s brw;
mbd_pkg::mbd_ptrb_s pb;
mbd_pkg::mbd_tail_s tl;
mbd_pkg::mbd_ret_s rt;
mbd_pkg::mbd_ptrb_s bk;

assign w = fetchWord;
assign bw = fetchWord;
assign cw = fetchWord;
assign brw = fetchWord;
assign pb = w.lo;
assign tl = w.lo;
assign rt = w.lo;
assign bk = w.lo;

// first word of a two-word instruction
function automatic logic firstOfTwo(
	input mbd_pkg::mbd_word_t x
);
	mbd_pkg::mbd_word_s xw;
	mbd_pkg::mbd_ctl_s xc;
	xw = x;
	xc = x;
	firstOfTwo = (xw.hi == mbd_pkg::NIB_CTRL) &&
		((xc.up == mbd_pkg::UP_CALL) ||
		(xw.mid == mbd_pkg::MID_JUMP) ||
		(xw.mid == mbd_pkg::MID_PTR));
endfunction : firstOfTwo

////////////////////////////////////////////////////////////////
// register port state

logic [7:0] ctrl_r;
logic [7:0] ctrl_nxt;
logic [7:0] tmrAddr_r;
logic [7:0] tmrAddr_nxt;
logic [7:0] portLo_r;
logic [7:0] portLo_nxt;
logic [7:0] portHi_r;
logic [7:0] portHi_nxt;
logic [7:0] illCnt_r;
logic [7:0] illCnt_nxt;
logic [7:0] rdata_r;
logic [7:0] rdata_nxt;

////////////////////////////////////////////////////////////////
// decode state

mbd_pkg::mbd_dec_s dec_r;
mbd_pkg::mbd_dec_s dec_nxt;
mbd_pkg::mbd_dec_s held_r;
mbd_pkg::mbd_dec_s held_nxt;
logic pend_r;
logic pend_nxt;
logic [1:0] squash_r;
logic [1:0] squash_nxt;
logic illEvt;
logic condFlag;
logic inPort;
logic onTimer;

always_comb begin
	case (brw.grp)
		mbd_pkg::CG_ZERO: condFlag = flagsIn[mbd_pkg::FI_ZERO];
		mbd_pkg::CG_CARRY: condFlag = flagsIn[mbd_pkg::FI_CARRY];
		mbd_pkg::CG_OVER: condFlag = flagsIn[mbd_pkg::FI_OVER];
		default: condFlag = flagsIn[mbd_pkg::FI_NEG];
	endcase
	// only the access bank reaches the special registers
	inPort = !bw.access && ctrl_r[mbd_pkg::CTRL_PINS] &&
		(bw.addr >= portLo_r) && (bw.addr <= portHi_r);
	onTimer = !bw.access && ctrl_r[mbd_pkg::CTRL_PSA] &&
		(bw.addr == tmrAddr_r);
end

always_comb begin
	dec_nxt = '0;
	held_nxt = held_r;
	pend_nxt = pend_r;
	squash_nxt = squash_r;
	illEvt = 1'b0;
	if (fetchValid) begin
		dec_nxt.valid = 1'b1;
		dec_nxt.cycles = mbd_pkg::CYC_ONE;
		if (squash_r != mbd_pkg::SQ_NONE) begin
			dec_nxt.squashed = 1'b1;
			squash_nxt = squash_r - mbd_pkg::SQ_ONE;
		end else if (pend_r) begin
			dec_nxt = held_r;
			dec_nxt.valid = 1'b1;
			pend_nxt = 1'b0;
			if (w.hi != mbd_pkg::NIB_OPERAND) begin
				// missing operand: held op reported bad
				dec_nxt.illegal = 1'b1;
				illEvt = 1'b1;
			end else if (held_r.op == mbd_pkg::OP_PTR_LOAD) begin
				dec_nxt.ptrValue = held_r.ptrValue |
					mbd_pkg::mbd_ptr_t'(w.lo);
				if (w.mid != mbd_pkg::MID_ZERO) begin
					dec_nxt.illegal = 1'b1;
					illEvt = 1'b1;
				end
			end else begin
				dec_nxt.target = {w.mid, w.lo, held_r.literal};
				squash_nxt = mbd_pkg::SQ_ONE;
			end
		end else begin
			case (w.hi)
				mbd_pkg::NIB_BIT_CLR,
				mbd_pkg::NIB_BIT_SET,
				mbd_pkg::NIB_BIT_TOG: begin
					dec_nxt.bitIdx = bw.bitIdx;
					dec_nxt.access = bw.access;
					dec_nxt.fileAddr = bw.addr;
					if (w.hi == mbd_pkg::NIB_BIT_CLR) begin
						dec_nxt.op = mbd_pkg::OP_BIT_CLR;
					end else if (w.hi == mbd_pkg::NIB_BIT_SET) begin
						dec_nxt.op = mbd_pkg::OP_BIT_SET;
					end else begin
						dec_nxt.op = mbd_pkg::OP_BIT_TOG;
					end
					dec_nxt.pinSource = inPort;
					dec_nxt.prescalerClear = onTimer;
				end
				mbd_pkg::NIB_SKIP_CLR,
				mbd_pkg::NIB_SKIP_SET: begin
					dec_nxt.bitIdx = bw.bitIdx;
					dec_nxt.access = bw.access;
					dec_nxt.fileAddr = bw.addr;
					if (w.hi == mbd_pkg::NIB_SKIP_CLR) begin
						dec_nxt.op = mbd_pkg::OP_SKIP_CLR;
						dec_nxt.skipTaken = !bitValue;
					end else begin
						dec_nxt.op = mbd_pkg::OP_SKIP_SET;
						dec_nxt.skipTaken = bitValue;
					end
					if (dec_nxt.skipTaken) begin
						if (firstOfTwo(nextWord)) begin
							dec_nxt.cycles = mbd_pkg::CYC_THREE;
							squash_nxt = mbd_pkg::SQ_TWO;
						end else begin
							dec_nxt.cycles = mbd_pkg::CYC_TWO;
							squash_nxt = mbd_pkg::SQ_ONE;
						end
					end
				end
				mbd_pkg::NIB_CTRL: begin
					dec_nxt.literal = w.lo;
					if (!brw.far) begin
						dec_nxt.op = mbd_pkg::OP_BRANCH;
						dec_nxt.branchTaken = condFlag ^ brw.inv;
						if (dec_nxt.branchTaken) begin
							dec_nxt.cycles = mbd_pkg::CYC_TWO;
							squash_nxt = mbd_pkg::SQ_ONE;
						end
					end else if (cw.up == mbd_pkg::UP_CALL) begin
						dec_nxt.op = mbd_pkg::OP_CALL;
						dec_nxt.fast = cw.fast;
					end else if (w.mid == mbd_pkg::MID_JUMP) begin
						dec_nxt.op = mbd_pkg::OP_JUMP;
					end else if (w.mid == mbd_pkg::MID_PTR &&
						pb.pad == mbd_pkg::PTR_PAD) begin
						dec_nxt.op = mbd_pkg::OP_PTR_LOAD;
						dec_nxt.ptrSel = pb.sel;
						dec_nxt.ptrValue = {pb.lit, 8'h00};
					end else begin
						dec_nxt.illegal = 1'b1;
						illEvt = 1'b1;
					end
					if (firstOfTwo(fetchWord) &&
						!dec_nxt.illegal) begin
						// nothing issues until operand word
						held_nxt = dec_nxt;
						held_nxt.valid = 1'b0;
						held_nxt.cycles = mbd_pkg::CYC_TWO;
						pend_nxt = 1'b1;
						// idle bundle stays all zero
						dec_nxt = '0;
					end
				end
				mbd_pkg::NIB_OPERAND: begin
					dec_nxt.op = mbd_pkg::OP_NONE;
				end
				mbd_pkg::NIB_ZERO: begin
					dec_nxt.literal = w.lo;
					case (w.mid)
						mbd_pkg::MID_ZERO: begin
							if (w.lo == mbd_pkg::LO_POP) begin
								dec_nxt.op = mbd_pkg::OP_POP;
							end else if (w.lo == mbd_pkg::LO_PUSH) begin
								dec_nxt.op = mbd_pkg::OP_PUSH;
							end else if (w.lo == mbd_pkg::LO_SLEEP) begin
								dec_nxt.op = mbd_pkg::OP_SLEEP;
								dec_nxt.standby = 1'b1;
								dec_nxt.tpStatusUpd = 1'b1;
							end else if (rt.head == mbd_pkg::LO_IRET) begin
								dec_nxt.op = mbd_pkg::OP_IRQ_RET;
								dec_nxt.fast = rt.fast;
								dec_nxt.irqReEnable = 1'b1;
								dec_nxt.cycles = mbd_pkg::CYC_TWO;
								squash_nxt = mbd_pkg::SQ_ONE;
							end else if (tl.head == mbd_pkg::LO_TBL_RD) begin
								dec_nxt.op = mbd_pkg::OP_TBL_READ;
								dec_nxt.tblMode = tl.mode;
								dec_nxt.cycles = mbd_pkg::CYC_TWO;
							end else if (tl.head == mbd_pkg::LO_TBL_WR) begin
								dec_nxt.op = mbd_pkg::OP_TBL_WRITE;
								dec_nxt.tblMode = tl.mode;
								dec_nxt.cycles = mbd_pkg::CYC_TWO;
							end else begin
								dec_nxt.illegal = 1'b1;
								illEvt = 1'b1;
							end
						end
						mbd_pkg::MID_BANK: begin
							if (bk.pad == mbd_pkg::PTR_PAD &&
								bk.sel == mbd_pkg::PTR_PAD) begin
								dec_nxt.op = mbd_pkg::OP_BANK_LOAD;
								dec_nxt.literal = {mbd_pkg::LO_BANK_HI,
									bk.lit};
							end else begin
								dec_nxt.illegal = 1'b1;
								illEvt = 1'b1;
							end
						end
						mbd_pkg::MID_ADDL: begin
							dec_nxt.op = mbd_pkg::OP_LIT_ADD;
							dec_nxt.flagMask = mbd_pkg::MASK_ARITH;
						end
						mbd_pkg::MID_SUBL: begin
							dec_nxt.op = mbd_pkg::OP_LIT_SUB;
							dec_nxt.flagMask = mbd_pkg::MASK_ARITH;
						end
						mbd_pkg::MID_ANDL: begin
							dec_nxt.op = mbd_pkg::OP_LIT_AND;
							dec_nxt.flagMask = mbd_pkg::MASK_LOGIC;
						end
						mbd_pkg::MID_ORL: begin
							dec_nxt.op = mbd_pkg::OP_LIT_OR;
							dec_nxt.flagMask = mbd_pkg::MASK_LOGIC;
						end
						mbd_pkg::MID_XORL: begin
							dec_nxt.op = mbd_pkg::OP_LIT_XOR;
							dec_nxt.flagMask = mbd_pkg::MASK_LOGIC;
						end
						mbd_pkg::MID_MOVL: begin
							dec_nxt.op = mbd_pkg::OP_LIT_MOVE;
						end
						mbd_pkg::MID_MULL: begin
							dec_nxt.op = mbd_pkg::OP_LIT_MUL;
						end
						mbd_pkg::MID_LRET: begin
							dec_nxt.op = mbd_pkg::OP_LIT_RET;
							dec_nxt.cycles = mbd_pkg::CYC_TWO;
							squash_nxt = mbd_pkg::SQ_ONE;
						end
						default: begin
							dec_nxt.illegal = 1'b1;
							illEvt = 1'b1;
						end
					endcase
				end
				default: begin
					dec_nxt.illegal = 1'b1;
					illEvt = 1'b1;
				end
			endcase
		end
	end
end

always_ff @(posedge ref_clk) begin
	if (!rst_b) begin
		dec_r <= '0;
		held_r <= '0;
		pend_r <= 1'b0;
		squash_r <= mbd_pkg::SQ_NONE;
	end else begin
		dec_r <= dec_nxt;
		held_r <= held_nxt;
		pend_r <= pend_nxt;
		squash_r <= squash_nxt;
	end
end

////////////////////////////////////////////////////////////////
// register port

always_comb begin
	ctrl_nxt = ctrl_r;
	tmrAddr_nxt = tmrAddr_r;
	portLo_nxt = portLo_r;
	portHi_nxt = portHi_r;
	illCnt_nxt = illCnt_r;
	rdata_nxt = '0;
	if (regWr) begin
		case (regAddr)
			mbd_pkg::A_CTRL: ctrl_nxt = regWdata;
			mbd_pkg::A_TMR: tmrAddr_nxt = regWdata;
			mbd_pkg::A_PLO: portLo_nxt = regWdata;
			mbd_pkg::A_PHI: portHi_nxt = regWdata;
			mbd_pkg::A_ILL: illCnt_nxt = '0;
			default: ;
		endcase
	end
	// a new event wins over a same-cycle clear; saturates
	if (illEvt && (illCnt_nxt != 8'hFF)) begin
		illCnt_nxt = illCnt_nxt + 8'h01;
	end
	if (regRd) begin
		case (regAddr)
			mbd_pkg::A_CTRL: rdata_nxt = ctrl_r;
			mbd_pkg::A_TMR: rdata_nxt = tmrAddr_r;
			mbd_pkg::A_PLO: rdata_nxt = portLo_r;
			mbd_pkg::A_PHI: rdata_nxt = portHi_r;
			mbd_pkg::A_ILL: rdata_nxt = illCnt_r;
			mbd_pkg::A_STATE: rdata_nxt = 8'({pend_r, squash_r});
			default: rdata_nxt = '0;
		endcase
	end
end

always_ff @(posedge ref_clk) begin
	if (!rst_b) begin
		ctrl_r <= mbd_pkg::RST_CTRL;
		tmrAddr_r <= mbd_pkg::RST_TMR;
		portLo_r <= mbd_pkg::RST_PLO;
		portHi_r <= mbd_pkg::RST_PHI;
		illCnt_r <= '0;
		rdata_r <= '0;
	end else begin
		ctrl_r <= ctrl_nxt;
		tmrAddr_r <= tmrAddr_nxt;
		portLo_r <= portLo_nxt;
		portHi_r <= portHi_nxt;
		illCnt_r <= illCnt_nxt;
		rdata_r <= rdata_nxt;
	end
end

assign regRdata = rdata_r;
assign decOut = dec_r;

endmodule : mbd_decoder
`default_nettype wire

// file: tb/mbd_decoder_properties.sv
// checker for mbd_decoder: decode timing, flag masks, flush slots
// assumes one core clock and a synchronous active-low reset
`timescale 1ns/1ps
`default_nettype none
module mbd_decoder_properties (
	input wire logic ref_clk,
	input wire logic rst_b,
	input wire logic fetchValid,
	input wire mbd_pkg::mbd_word_t fetchWord,
	input wire logic bitValue,
	input wire mbd_pkg::mbd_dec_s decOut
);
	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (!rst_b);
	mbd_pkg::mbd_bitw_s prevW_r;
	logic ok;
	always_ff @(posedge ref_clk) begin
		prevW_r <= fetchWord;
	end
	assign ok = decOut.valid && !decOut.squashed && !decOut.illegal;
////////////////////////////////////////////////////////////////////////
	sequence sFlush;
		ok && (decOut.skipTaken || decOut.branchTaken ||
			decOut.op inside {mbd_pkg::OP_CALL, mbd_pkg::OP_JUMP,
			mbd_pkg::OP_LIT_RET, mbd_pkg::OP_IRQ_RET});
	endsequence
	sequence sSkipLong;
		ok && decOut.skipTaken && decOut.cycles == mbd_pkg::CYC_THREE;
	endsequence
	AST_FLUSH_SLOT: assert property (
		sFlush ##0 fetchValid |=> decOut.valid && decOut.squashed)
		else $error("slot after flush not squashed");
	AST_SKIP_TWO: assert property (
		sSkipLong ##0 fetchValid [*2] |=> decOut.squashed)
		else $error("second skipped slot not squashed");
	AST_SKIP_CYC: assert property (
		ok && decOut.op inside {mbd_pkg::OP_SKIP_CLR, mbd_pkg::OP_SKIP_SET}
		|-> decOut.flagMask == 5'h00 && decOut.skipTaken ==
		($past(bitValue) == (decOut.op == mbd_pkg::OP_SKIP_SET)) &&
		(decOut.skipTaken ? decOut.cycles != mbd_pkg::CYC_ONE :
		decOut.cycles == mbd_pkg::CYC_ONE))
		else $error("bit test skip wrong");
	AST_BRANCH: assert property (
		ok && decOut.op == mbd_pkg::OP_BRANCH |-> decOut.cycles ==
		(decOut.branchTaken ? mbd_pkg::CYC_TWO : mbd_pkg::CYC_ONE))
		else $error("branch cycle count wrong");
	AST_TWO_WORD: assert property (
		ok && decOut.op inside {mbd_pkg::OP_CALL, mbd_pkg::OP_JUMP,
		mbd_pkg::OP_PTR_LOAD} |-> decOut.cycles == mbd_pkg::CYC_TWO &&
		prevW_r.hi == mbd_pkg::NIB_OPERAND)
		else $error("two-word result wrong");
	AST_BIT_CLEAR: assert property (
		ok && prevW_r.hi == mbd_pkg::NIB_BIT_CLR |->
		decOut.op == mbd_pkg::OP_BIT_CLR && decOut.bitIdx == prevW_r.bitIdx
		&& decOut.access == prevW_r.access && decOut.fileAddr == prevW_r.addr)
		else $error("bit clear fields wrong");
	AST_ARITH: assert property (
		ok && decOut.op inside {mbd_pkg::OP_LIT_ADD, mbd_pkg::OP_LIT_SUB}
		|-> decOut.flagMask == mbd_pkg::MASK_ARITH &&
		decOut.literal == prevW_r.addr)
		else $error("arith literal wrong");
	AST_LOGIC: assert property (
		ok && decOut.op inside {mbd_pkg::OP_LIT_AND, mbd_pkg::OP_LIT_OR,
		mbd_pkg::OP_LIT_XOR} |-> decOut.flagMask == mbd_pkg::MASK_LOGIC)
		else $error("logic literal mask wrong");
	AST_NOFLAG: assert property (
		ok && decOut.op inside {mbd_pkg::OP_LIT_MOVE, mbd_pkg::OP_LIT_MUL}
		|-> decOut.flagMask == 5'h00 && decOut.cycles == mbd_pkg::CYC_ONE)
		else $error("move or multiply touched flags");
	AST_IRET: assert property (
		ok && decOut.op == mbd_pkg::OP_IRQ_RET |-> decOut.irqReEnable &&
		decOut.cycles == mbd_pkg::CYC_TWO && decOut.fast == prevW_r.addr[0])
		else $error("interrupt return wrong");
	AST_SLEEP: assert property (
		ok && decOut.op == mbd_pkg::OP_SLEEP |-> decOut.standby &&
		decOut.tpStatusUpd && decOut.cycles == mbd_pkg::CYC_ONE)
		else $error("standby word wrong");
	AST_TABLE: assert property (
		ok && decOut.op inside {mbd_pkg::OP_TBL_READ, mbd_pkg::OP_TBL_WRITE}
		|-> decOut.cycles == mbd_pkg::CYC_TWO &&
		decOut.tblMode == prevW_r.addr[1:0])
		else $error("table op wrong");
	AST_IDLE_ZERO: assert property (
		!decOut.valid |-> decOut == '0)
		else $error("idle decode bundle not zero");
endmodule : mbd_decoder_properties
bind mbd_decoder mbd_decoder_properties mbd_decoder_properties_inst (
	.ref_clk(ref_clk), .rst_b(rst_b), .fetchValid(fetchValid),
	.fetchWord(fetchWord), .bitValue(bitValue), .decOut(decOut));
`default_nettype wire

// file: tb/mbd_fetch_model.sv
// fetch stage model: streams queued program words to the decoder
// assumes the bench queues words away from the rising edge
`timescale 1ns/1ps
`default_nettype none
module mbd_fetch_model (
	input wire logic ref_clk,
	input wire logic rst_b,
	input wire logic slow,
	output logic fetchValid,
	output var mbd_pkg::mbd_word_t fetchWord,
	output var mbd_pkg::mbd_word_t nextWord,
	output logic bitValue
);
	logic [16:0] q[$];
	task automatic put(input logic [15:0] w, input logic b);
		q.push_back({b, w});
	endtask : put
	initial begin
		fetchValid = 1'b0;
		fetchWord = 16'h0000;
		nextWord = 16'hFFFF;
		bitValue = 1'b0;
	end
	// slow mode leaves an idle cycle between words
	always @(posedge ref_clk) begin
		if (rst_b && q.size() != 0 && !(slow && fetchValid)) begin
			fetchValid <= 1'b1;
			{bitValue, fetchWord} <= q[0];
			nextWord <= (q.size() > 1) ? q[1][15:0] : ~q[0][15:0];
			void'(q.pop_front());
		end else begin
			// idle lines never keep the last word
			fetchValid <= 1'b0;
			fetchWord <= ~fetchWord;
			nextWord <= ~nextWord;
			bitValue <= ~bitValue;
		end
	end
endmodule : mbd_fetch_model
`default_nettype wire

// file: tb/mbd_decoder_tb.sv
// bench for mbd_decoder: registers, literal, control, bit, table words
// assumes the fetch model supplies words and tested bits
`timescale 1ns/1ps
`default_nettype none
module mbd_decoder_tb;
	logic ref_clk = 1'b0;
	logic rst_b = 1'b0;
	logic slow = 1'b0;
	logic regWr = 1'b0;
	logic regRd = 1'b0;
	logic [2:0] regAddr = 3'h0;
	logic [7:0] regWdata = 8'h00;
	logic [4:0] flagsIn = 5'h00;
	logic fetchValid;
	logic bitValue;
	mbd_pkg::mbd_word_t fetchWord;
	mbd_pkg::mbd_word_t nextWord;
	logic [7:0] regRdata;
	mbd_pkg::mbd_dec_s decOut;
	mbd_pkg::mbd_dec_s resQ[$];
	mbd_pkg::mbd_dec_s r;
	logic [16:0] p[$];
	logic [7:0] rv[8];
	logic tk[8];
	int error_cnt = 0;
	int checks = 0;
	int cyc = 0;
	mbd_decoder mbd_decoder_inst (.ref_clk(ref_clk), .rst_b(rst_b),
		.fetchValid(fetchValid), .fetchWord(fetchWord), .nextWord(nextWord),
		.flagsIn(flagsIn), .bitValue(bitValue), .regAddr(regAddr),
		.regWdata(regWdata), .regWr(regWr), .regRd(regRd),
		.regRdata(regRdata), .decOut(decOut));
	mbd_fetch_model mbd_fetch_model_inst (.ref_clk(ref_clk), .rst_b(rst_b),
		.slow(slow), .fetchValid(fetchValid), .fetchWord(fetchWord),
		.nextWord(nextWord), .bitValue(bitValue));
	always #25 ref_clk = ~ref_clk;
	// ceiling well above the roughly 180 cycles the tests need
	always @(posedge ref_clk) begin
		cyc <= cyc + 1;
		if (cyc == 3000) begin
			error_cnt = error_cnt + 1;
			summarize();
		end
	end
	always @(negedge ref_clk) begin
		if (decOut.valid === 1'b1)
			resQ.push_back(decOut);
	end
////////////////////////////////////////////////////////////////////////
	task automatic summarize();
		$display("checks %0d mismatches %0d", checks, error_cnt);
		if (error_cnt == 0 && checks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask : summarize
	task automatic cmpv(input string n, input logic [19:0] e,
		input logic [19:0] g);
		checks++;
		if (g !== e) begin
			error_cnt++;
			$display("BAD %s exp %h got %h", n, e, g);
		end
	endtask : cmpv
	// key: op, cycles, flag mask, squashed, illegal, any side effect
	task automatic chk(input mbd_pkg::mbd_op_e op, input logic [1:0] cy,
		input logic [4:0] m, input logic [2:0] fl);
		logic [14:0] g;
		g = 15'h7FFF;
		if (resQ.size() != 0) begin
			r = resQ.pop_front();
			g = {r.op, r.cycles, r.flagMask, r.squashed, r.illegal,
				r.skipTaken | r.branchTaken | r.fast | r.irqReEnable |
				r.standby | r.pinSource | r.prescalerClear};
		end
		checks++;
		if (g !== {op, cy, m, fl}) begin
			error_cnt++;
			$display("BAD decode exp %h got %h", {op, cy, m, fl}, g);
		end
	endtask : chk
	task automatic sq();
		chk(mbd_pkg::OP_NONE, mbd_pkg::CYC_ONE, 5'h00, 3'h4);
	endtask : sq
	task automatic wr(input logic [2:0] a, input logic [7:0] d);
		regAddr <= a;
		regWdata <= d;
		regWr <= 1'b1;
		@(posedge ref_clk);
		regWr <= 1'b0;
		@(posedge ref_clk);
	endtask : wr
	task automatic rd(input logic [2:0] a, input logic [7:0] e);
		regAddr <= a;
		regRd <= 1'b1;
		@(posedge ref_clk);
		regRd <= 1'b0;
		#1;
		cmpv("reg data", {12'h000, e}, {12'h000, regRdata});
		@(posedge ref_clk);
	endtask : rd
	task automatic ld(input logic [16:0] w[$]);
		resQ.delete();
		@(negedge ref_clk);
		foreach (w[i])
			mbd_fetch_model_inst.put(w[i][15:0], w[i][16]);
		repeat (w.size() * 2 + 4) @(posedge ref_clk);
	endtask : ld
	task automatic fin(input string n);
		cmpv("extra results", 20'h00000, 20'(resQ.size()));
		$display("test %s done", n);
	endtask : fin
////////////////////////////////////////////////////////////////////////
	initial begin
		repeat (6) @(posedge ref_clk);
		rst_b <= 1'b1;
		@(posedge ref_clk);
		rv = '{mbd_pkg::RST_CTRL, mbd_pkg::RST_TMR, mbd_pkg::RST_PLO,
			mbd_pkg::RST_PHI, 8'h00, 8'h00, 8'h00, 8'h00};
		wr(mbd_pkg::A_STATE, 8'hFF);
		for (int i = 0; i < 8; i++)
			rd(i[2:0], rv[i]);
		fin("registers");
		ld('{17'h00F15, 17'h00812, 17'h00B33, 17'h00934, 17'h00A35,
			17'h00E36, 17'h00D37, 17'h00105, 17'h00C40, 17'h00E01});
		chk(mbd_pkg::OP_LIT_ADD, 2'h1, 5'h1F, 3'h0);
		cmpv("literal", 20'h00015, {12'h000, r.literal});
		chk(mbd_pkg::OP_LIT_SUB, 2'h1, 5'h1F, 3'h0);
		chk(mbd_pkg::OP_LIT_AND, 2'h1, 5'h14, 3'h0);
		chk(mbd_pkg::OP_LIT_OR, 2'h1, 5'h14, 3'h0);
		chk(mbd_pkg::OP_LIT_XOR, 2'h1, 5'h14, 3'h0);
		chk(mbd_pkg::OP_LIT_MOVE, 2'h1, 5'h00, 3'h0);
		chk(mbd_pkg::OP_LIT_MUL, 2'h1, 5'h00, 3'h0);
		chk(mbd_pkg::OP_BANK_LOAD, 2'h1, 5'h00, 3'h0);
		cmpv("bank", 20'h00005, {12'h000, r.literal});
		chk(mbd_pkg::OP_LIT_RET, 2'h2, 5'h00, 3'h0);
		sq();
		fin("literal");
		ld('{17'h0EC12, 17'h0F345, 17'h0E000, 17'h0EF01, 17'h0F002,
			17'h00E00, 17'h0EE1A, 17'h0F0BC, 17'h0F123, 17'h0ED00,
			17'h0F000, 17'h00E01, 17'h0EF10, 17'h00E00, 17'h0E800});
		chk(mbd_pkg::OP_CALL, 2'h2, 5'h00, 3'h0);
		cmpv("target", 20'h34512, r.target);
		sq();
		chk(mbd_pkg::OP_JUMP, 2'h2, 5'h00, 3'h0);
		cmpv("target", 20'h00201, r.target);
		sq();
		chk(mbd_pkg::OP_PTR_LOAD, 2'h2, 5'h00, 3'h0);
		cmpv("pointer", 20'h01ABC, {6'h00, r.ptrSel, r.ptrValue});
		chk(mbd_pkg::OP_NONE, 2'h1, 5'h00, 3'h0);
		chk(mbd_pkg::OP_CALL, 2'h2, 5'h00, 3'h1);
		sq();
		chk(mbd_pkg::OP_JUMP, 2'h2, 5'h00, 3'h2);
		chk(mbd_pkg::OP_NONE, 2'h1, 5'h00, 3'h2);
		fin("two-word");
		wr(mbd_pkg::A_CTRL, 8'h03);
		wr(mbd_pkg::A_TMR, 8'h01);
		ld('{17'h09C82, 17'h08E01, 17'h07301, 17'h0B201, 17'h0EF00,
			17'h0F000, 17'h1A201, 17'h00E00, 17'h0A201, 17'h00E00});
		chk(mbd_pkg::OP_BIT_CLR, 2'h1, 5'h00, 3'h1);
		cmpv("bit fields", 20'h00C82, {r.bitIdx, r.access, r.fileAddr});
		chk(mbd_pkg::OP_BIT_SET, 2'h1, 5'h00, 3'h1);
		chk(mbd_pkg::OP_BIT_TOG, 2'h1, 5'h00, 3'h0);
		chk(mbd_pkg::OP_SKIP_CLR, 2'h3, 5'h00, 3'h1);
		sq();
		sq();
		chk(mbd_pkg::OP_SKIP_SET, 2'h2, 5'h00, 3'h1);
		sq();
		chk(mbd_pkg::OP_SKIP_SET, 2'h1, 5'h00, 3'h0);
		chk(mbd_pkg::OP_LIT_MOVE, 2'h1, 5'h00, 3'h0);
		fin("bit");
		// zero flag set, all others clear
		flagsIn <= 5'h04;
		p.delete();
		for (int c = 0; c < 8; c++) begin
			tk[c] = (c == 0) || (c != 1 && c % 2 == 1);
			p.push_back({5'h0E, 1'b0, c[2:0], 8'h05});
			if (tk[c])
				p.push_back(17'h00E00);
		end
		ld(p);
		for (int c = 0; c < 8; c++) begin
			chk(mbd_pkg::OP_BRANCH, tk[c] ? 2'h2 : 2'h1, 5'h00,
				{2'h0, tk[c]});
			if (tk[c])
				sq();
		end
		fin("branch");
		slow <= 1'b1;
		ld('{17'h00006, 17'h00005, 17'h00003, 17'h00011, 17'h00E00,
			17'h00004, 17'h00000, 17'h00008, 17'h00009, 17'h0000A,
			17'h0000B, 17'h0000C, 17'h0000D, 17'h0000E, 17'h0000F});
		chk(mbd_pkg::OP_POP, 2'h1, 5'h00, 3'h0);
		chk(mbd_pkg::OP_PUSH, 2'h1, 5'h00, 3'h0);
		chk(mbd_pkg::OP_SLEEP, 2'h1, 5'h00, 3'h1);
		chk(mbd_pkg::OP_IRQ_RET, 2'h2, 5'h00, 3'h1);
		sq();
		chk(mbd_pkg::OP_NONE, 2'h1, 5'h00, 3'h2);
		chk(mbd_pkg::OP_NONE, 2'h1, 5'h00, 3'h2);
		for (int i = 0; i < 8; i++) begin
			chk(i < 4 ? mbd_pkg::OP_TBL_READ : mbd_pkg::OP_TBL_WRITE,
				2'h2, 5'h00, 3'h0);
			cmpv("table mode", 20'(i % 4), {18'h0, r.tblMode});
		end
		rd(mbd_pkg::A_ILL, 8'h04);
		wr(mbd_pkg::A_ILL, 8'h55);
		rd(mbd_pkg::A_ILL, 8'h00);
		fin("misc");
		summarize();
	end
endmodule : mbd_decoder_tb
`default_nettype wire
